// file: rtl/fhd_host_drive.sv
// host side and drive side control of a floppy disk controller
// assumes host strobes, selects and drive inputs are synchronous to CLOCK
//
// Overview of operation
// - fixed precompensation: 125 ns at 250k, 300k, 500k; 83 ns at 1M
// - scaled precompensation: 83, 125, 208, 250 ns for 1M, 500k, 300k, 250k
// - address lines pick the register; ignored during dma transfers
// - register strobes honoured only while host select is low
// - dma acknowledge low answers a request and enables the strobes
// - dma request high tells the dma controller a byte is needed
// - dma acknowledge and request work only while drive control bit 3 set
// - step direction low moves head inward, high moves it outward
// - step direction held high during read or write operation
// - spindle type low with 300k selected runs at 250k
// - spindle type high with 300k selected runs at 300k
// - drive 0 select low when drive 0 decoded and motor 0 enabled
// - drive 1 select from drive 1 decode and motor 1 enable
// - loop filter switched automatically by the effective data rate
// - cylinder numbers span up to 4096 tracks for seeks
// - drive 2 and 3 selects built like drive 0
// - interrupt output high for attention, works only with bit 3 set
// - media changed latched, inverted, read on bit 7 at offset seven
`timescale 1ns/100ps
module fhd_host_drive #(
  parameter int CYL_WIDTH = fhd_pkg::FHD_CYL_WIDTH,
  parameter int STEP_CYCLES = fhd_pkg::FHD_STEP_CYCLES,
  parameter int PULSE_CYCLES = fhd_pkg::FHD_PULSE_CYCLES
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // host bus
  input wire fhd_pkg::fhd_bus_req_t HOST_BUS,
  input wire logic HOST_SEL_N,
  input wire logic DMA_ACK_N,
  output logic [7:0] HOST_RDATA,
  // dma and interrupt
  output logic DMA_REQUEST,
  output logic INTERRUPT,
  // controller core side
  input wire logic CORE_XFER_NEEDED,
  input wire logic CORE_ATTENTION,
  input wire logic [7:0] CORE_RDATA,
  output logic [7:0] CORE_WDATA,
  output logic CORE_WR,
  output logic CORE_RD,
  output logic [7:0] PRECOMP_NS,
  output logic [1:0] EFFECTIVE_RATE,
  // drive side
  input wire logic SPINDLE_TYPE_IN,
  input wire logic MEDIA_CHANGED_IN,
  output logic DRIVE0_SELECT_N,
  output logic DRIVE1_SELECT_N,
  output logic DRIVE2_SELECT_N,
  output logic DRIVE3_SELECT_N,
  output logic MOTOR0_ENABLE_OUT,
  output logic MOTOR1_ENABLE_OUT,
  output logic MOTOR2_ENABLE_OUT,
  output logic MOTOR3_ENABLE_OUT,
  output logic SPINDLE_SPEED_LOW_CURRENT,
  output logic STEP_OUT,
  output logic STEP_DIR_OUT,
  // loop filter switches
  output logic FILTER_LOW_RATE_ON,
  output logic FILTER_MID_RATE_ON
);

  // ==========================================================
  // declarations
  logic [7:0] drive_ctl_q;
  logic [7:0] op_ctl_q;
  logic [1:0] rate_sel_q;
  logic [CYL_WIDTH-1:0] target_q;
  logic media_q;
  logic dma_req_q;
  logic int_q;
  logic [7:0] rdata_q;
  logic [7:0] core_wdata_q;
  logic core_wr_q;
  logic core_rd_q;
  logic [7:0] precomp_q;
  logic [1:0] eff_rate_q;
  logic [3:0] drive_sel_n_q;
  logic filt_low_q;
  logic filt_mid_q;
  logic dma_en;
  logic dma_cycle;
  logic reg_cycle;
  logic reg_wr;
  logic reg_rd;
  logic dma_wr;
  logic dma_rd;
  logic [1:0] eff_rate_d;
  logic [7:0] precomp_d;
  logic [7:0] rdata_d;
  logic [CYL_WIDTH-1:0] cylinder;
  logic seeking;
  logic rw_active;

  // ==========================================================
  // access qualification
  // dma enable comes straight from drive control bit 3
  assign dma_en = drive_ctl_q[fhd_pkg::FHD_DC_DMA_EN];

  // acknowledge counts only when dma is enabled
  assign dma_cycle = dma_en && !DMA_ACK_N;

  // register cycle needs host select low and no dma cycle
  assign reg_cycle = !HOST_SEL_N && !dma_cycle;

  // register strobes, address decoded below
  assign reg_wr = reg_cycle && HOST_BUS.wr;
  assign reg_rd = reg_cycle && HOST_BUS.rd;

  // dma strobes go to the data port whatever the address
  assign dma_wr = dma_cycle && HOST_BUS.wr;
  assign dma_rd = dma_cycle && HOST_BUS.rd;

  // ==========================================================
  // drive control register
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      drive_ctl_q <= fhd_pkg::FHD_DC_RESET;
    end else if (reg_wr && HOST_BUS.addr == fhd_pkg::FHD_OFS_DRIVE_CTL) begin
      drive_ctl_q <= HOST_BUS.wdata;
    end
  end

  // operation control register
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      op_ctl_q <= fhd_pkg::FHD_OC_RESET;
    end else if (reg_wr && HOST_BUS.addr == fhd_pkg::FHD_OFS_OP_CTL) begin
      op_ctl_q <= HOST_BUS.wdata;
    end
  end

  // data rate register, low two bits
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rate_sel_q <= fhd_pkg::FHD_RATE_RESET;
    end else if (reg_wr && HOST_BUS.addr == fhd_pkg::FHD_OFS_RATE) begin
      rate_sel_q <= HOST_BUS.wdata[1:0];
    end
  end

  // seek target, split over two offsets
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      target_q <= '0;
    end else if (reg_wr && HOST_BUS.addr == fhd_pkg::FHD_OFS_TARGET_LO) begin
      target_q[7:0] <= HOST_BUS.wdata;
    end else if (reg_wr && HOST_BUS.addr == fhd_pkg::FHD_OFS_TARGET_HI) begin
      target_q[CYL_WIDTH-1:8] <= HOST_BUS.wdata[CYL_WIDTH-9:0];
    end
  end

  // ==========================================================
  // media changed input, latched every cycle
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      media_q <= 1'b0;
    end else begin
      media_q <= MEDIA_CHANGED_IN;
    end
  end

  // ==========================================================
  // dma request flag: core sets, dma byte transfer clears, set wins
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      dma_req_q <= 1'b0;
    end else if (!dma_en) begin
      dma_req_q <= 1'b0;
    end else if (CORE_XFER_NEEDED) begin
      dma_req_q <= 1'b1;
    end else if (dma_wr || dma_rd) begin
      dma_req_q <= 1'b0;
    end
  end

  // interrupt follows core attention while enabled
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      int_q <= 1'b0;
    end else begin
      int_q <= dma_en && CORE_ATTENTION;
    end
  end

  // ==========================================================
  // data port toward the controller core
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      core_wdata_q <= 8'h00;
      core_wr_q <= 1'b0;
    end else begin
      core_wr_q <= dma_wr || (reg_wr && HOST_BUS.addr == fhd_pkg::FHD_OFS_DATA);
      if (dma_wr || (reg_wr && HOST_BUS.addr == fhd_pkg::FHD_OFS_DATA)) begin
        core_wdata_q <= HOST_BUS.wdata;
      end
    end
  end

  // read pulse toward the core, one cycle after the strobe
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      core_rd_q <= 1'b0;
    end else begin
      core_rd_q <= dma_rd || (reg_rd && HOST_BUS.addr == fhd_pkg::FHD_OFS_DATA);
    end
  end

  // ==========================================================
  // read data mux, zero for no access or unmapped offsets
  always_comb begin
    rdata_d = 8'h00;
    if (dma_rd) begin
      rdata_d = CORE_RDATA;
    end else if (reg_rd) begin
      case (HOST_BUS.addr)
        fhd_pkg::FHD_OFS_TARGET_LO: rdata_d = cylinder[7:0];
        fhd_pkg::FHD_OFS_TARGET_HI: rdata_d = 8'(cylinder[CYL_WIDTH-1:8]);
        fhd_pkg::FHD_OFS_DRIVE_CTL: rdata_d = drive_ctl_q;
        fhd_pkg::FHD_OFS_OP_CTL: rdata_d = op_ctl_q;
        fhd_pkg::FHD_OFS_STATUS: rdata_d = {seeking, dma_req_q, int_q, STEP_DIR_OUT,
                                           filt_mid_q, filt_low_q, eff_rate_q};
        fhd_pkg::FHD_OFS_DATA: rdata_d = CORE_RDATA;
        fhd_pkg::FHD_OFS_RATE: rdata_d[fhd_pkg::FHD_MEDIA_BIT] = !media_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // effective rate with spindle type substitution
  always_comb begin
    eff_rate_d = rate_sel_q;
    if (rate_sel_q == fhd_pkg::FHD_RATE_300K && !SPINDLE_TYPE_IN) begin
      eff_rate_d = fhd_pkg::FHD_RATE_250K;
    end else if (rate_sel_q == fhd_pkg::FHD_RATE_300K) begin
      eff_rate_d = fhd_pkg::FHD_RATE_300K;
    end
  end

  // precompensation amount from mode and effective rate
  always_comb begin
    precomp_d = fhd_pkg::FHD_PRECOMP_FIXED_NS;
    if (op_ctl_q[fhd_pkg::FHD_OC_SCALED]) begin
      case (eff_rate_d)
        fhd_pkg::FHD_RATE_1M: precomp_d = fhd_pkg::FHD_PRECOMP_1M_NS;
        fhd_pkg::FHD_RATE_500K: precomp_d = fhd_pkg::FHD_PRECOMP_500K_NS;
        fhd_pkg::FHD_RATE_300K: precomp_d = fhd_pkg::FHD_PRECOMP_300K_NS;
        fhd_pkg::FHD_RATE_250K: precomp_d = fhd_pkg::FHD_PRECOMP_250K_NS;
        default: precomp_d = fhd_pkg::FHD_PRECOMP_FIXED_NS;
      endcase
    end else if (eff_rate_d == fhd_pkg::FHD_RATE_1M) begin
      precomp_d = fhd_pkg::FHD_PRECOMP_1M_NS;
    end else begin
      precomp_d = fhd_pkg::FHD_PRECOMP_FIXED_NS;
    end
  end

  // rate, precompensation and filter registers
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      eff_rate_q <= fhd_pkg::FHD_RATE_RESET;
      precomp_q <= fhd_pkg::FHD_PRECOMP_FIXED_NS;
      filt_low_q <= 1'b0;
      filt_mid_q <= 1'b1;
    end else begin
      eff_rate_q <= eff_rate_d;
      precomp_q <= precomp_d;
      // low filter for 250k and 300k, mid for 500k, none for 1M
      filt_low_q <= (eff_rate_d == fhd_pkg::FHD_RATE_250K)
                 || (eff_rate_d == fhd_pkg::FHD_RATE_300K);
      filt_mid_q <= eff_rate_d == fhd_pkg::FHD_RATE_500K;
    end
  end

  // ==========================================================
  // drive selects: decode anded with matching motor enable
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      drive_sel_n_q <= 4'hf;
    end else begin
      for (int i = 0; i < 4; i++) begin
        drive_sel_n_q[i] <= !((drive_ctl_q[fhd_pkg::FHD_DC_SEL_LSB +: 2] == 2'(i))
                           && drive_ctl_q[fhd_pkg::FHD_DC_MOTOR_LSB + i]);
      end
    end
  end

  // ==========================================================
  // head positioning
  assign rw_active = op_ctl_q[fhd_pkg::FHD_OC_READ] || op_ctl_q[fhd_pkg::FHD_OC_WRITE];

  // stepper with 12 bit cylinder range
  fhd_seek #(
    .CYL_WIDTH(CYL_WIDTH),
    .STEP_CYCLES(STEP_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_seek (
    .clk(CLOCK),
    .rst_n(RESETN),
    .target(target_q),
    .rw_active(rw_active),
    .step_out(STEP_OUT),
    .step_dir_out(STEP_DIR_OUT),
    .cylinder(cylinder),
    .seeking(seeking)
  );

  // ==========================================================
  // outputs
  assign HOST_RDATA = rdata_q;
  assign DMA_REQUEST = dma_req_q;
  assign INTERRUPT = int_q;
  assign CORE_WDATA = core_wdata_q;
  assign CORE_WR = core_wr_q;
  assign CORE_RD = core_rd_q;
  assign PRECOMP_NS = precomp_q;
  assign EFFECTIVE_RATE = eff_rate_q;
  assign DRIVE0_SELECT_N = drive_sel_n_q[0];
  assign DRIVE1_SELECT_N = drive_sel_n_q[1];
  assign DRIVE2_SELECT_N = drive_sel_n_q[2];
  assign DRIVE3_SELECT_N = drive_sel_n_q[3];
  assign MOTOR0_ENABLE_OUT = drive_ctl_q[fhd_pkg::FHD_DC_MOTOR_LSB];
  assign MOTOR1_ENABLE_OUT = drive_ctl_q[fhd_pkg::FHD_DC_MOTOR_LSB + 1];
  assign MOTOR2_ENABLE_OUT = drive_ctl_q[fhd_pkg::FHD_DC_MOTOR_LSB + 2];
  assign MOTOR3_ENABLE_OUT = drive_ctl_q[fhd_pkg::FHD_DC_MOTOR_LSB + 3];
  // high when a high density rate is in use
  assign SPINDLE_SPEED_LOW_CURRENT = !filt_low_q;
  assign FILTER_LOW_RATE_ON = filt_low_q;
  assign FILTER_MID_RATE_ON = filt_mid_q;

endmodule

// file: rtl/fhd_pkg.sv
// package for the floppy host and drive control block
// assumes one 10 MHz clock domain shared by every user of these constants
package fhd_pkg;

  // ==========================================================
  // register offsets on the three host address lines
  localparam logic [2:0] FHD_OFS_TARGET_LO = 3'h0; // seek target bits 7:0
  localparam logic [2:0] FHD_OFS_TARGET_HI = 3'h1; // seek target bits 11:8
  localparam logic [2:0] FHD_OFS_DRIVE_CTL = 3'h2; // drive control
  localparam logic [2:0] FHD_OFS_OP_CTL = 3'h3;    // operation control
  localparam logic [2:0] FHD_OFS_STATUS = 3'h4;    // block state, read only
  localparam logic [2:0] FHD_OFS_DATA = 3'h5;      // data byte port
  localparam logic [2:0] FHD_OFS_RATE = 3'h7;      // rate write, media read

  // ==========================================================
  // drive control field positions and reset value
  localparam int FHD_DC_SEL_LSB = 0;   // two drive select bits
  localparam int FHD_DC_DMA_EN = 3;    // dma and interrupt enable
  localparam int FHD_DC_MOTOR_LSB = 4; // four motor enables
  localparam logic [7:0] FHD_DC_RESET = 8'h00;

  // operation control field positions and reset value
  localparam int FHD_OC_SCALED = 0;    // scaled precompensation mode
  localparam int FHD_OC_READ = 1;      // read operation active
  localparam int FHD_OC_WRITE = 2;     // write operation active
  localparam logic [7:0] FHD_OC_RESET = 8'h00;

  // media changed bit in the register at offset seven
  localparam int FHD_MEDIA_BIT = 7;

  // ==========================================================
  // data rate codes
  localparam logic [1:0] FHD_RATE_500K = 2'h0;
  localparam logic [1:0] FHD_RATE_300K = 2'h1;
  localparam logic [1:0] FHD_RATE_250K = 2'h2;
  localparam logic [1:0] FHD_RATE_1M = 2'h3;
  localparam logic [1:0] FHD_RATE_RESET = 2'h0;

  // precompensation shifts in nanoseconds
  localparam logic [7:0] FHD_PRECOMP_FIXED_NS = 8'd125;
  localparam logic [7:0] FHD_PRECOMP_1M_NS = 8'd83;
  localparam logic [7:0] FHD_PRECOMP_500K_NS = 8'd125;
  localparam logic [7:0] FHD_PRECOMP_300K_NS = 8'd208;
  localparam logic [7:0] FHD_PRECOMP_250K_NS = 8'd250;

  // ==========================================================
  // cylinder range and step timing
  localparam int FHD_CYL_WIDTH = 12;           // up to 4096 tracks
  localparam int FHD_CLOCK_HZ = 10_000_000;
  localparam int FHD_STEP_PERIOD_US = 3000;    // time between step pulses
  localparam int FHD_STEP_CYCLES = FHD_STEP_PERIOD_US * (FHD_CLOCK_HZ / 1_000_000);
  localparam int FHD_STEP_PULSE_US = 1;        // width of one step pulse
  localparam int FHD_PULSE_CYCLES = FHD_STEP_PULSE_US * (FHD_CLOCK_HZ / 1_000_000);

  // ==========================================================
  // one host bus cycle
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fhd_bus_req_t;

endpackage

// file: rtl/fhd_seek.sv
// cylinder tracker and step generator for the selected drive
// assumes targets come from the register file in the same clock domain
`timescale 1ns/100ps
module fhd_seek #(
  parameter int CYL_WIDTH = fhd_pkg::FHD_CYL_WIDTH,
  parameter int STEP_CYCLES = fhd_pkg::FHD_STEP_CYCLES,
  parameter int PULSE_CYCLES = fhd_pkg::FHD_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic [CYL_WIDTH-1:0] target,
  input wire logic rw_active,
  // drive side
  output logic step_out,
  output logic step_dir_out,
  // state
  output logic [CYL_WIDTH-1:0] cylinder,
  output logic seeking
);

  logic [CYL_WIDTH-1:0] cyl_q;
  logic [31:0] timer_q;
  logic step_q;
  logic dir_q;
  logic moving;
  logic inward;

  // ==========================================================
  // direction toward target, no stepping during read or write
  assign moving = (target != cyl_q) && !rw_active;
  assign inward = target > cyl_q;

  // step pacing and cylinder count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyl_q <= '0;
      timer_q <= 32'h0;
      step_q <= 1'b0;
    end else if (timer_q != 32'h0) begin
      timer_q <= timer_q - 32'h1;
      if (timer_q == 32'(STEP_CYCLES - PULSE_CYCLES)) begin
        step_q <= 1'b0;
      end
    end else if (moving) begin
      // minus one so that steps are exactly STEP_CYCLES apart and high PULSE_CYCLES
      timer_q <= 32'(STEP_CYCLES - 1);
      step_q <= 1'b1;
      cyl_q <= inward ? cyl_q + 1'b1 : cyl_q - 1'b1;
    end
  end

  // direction: low steps in, high steps out, high during read or write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= 1'b1;
    end else if (rw_active) begin
      dir_q <= 1'b1;
    end else if (moving && timer_q == 32'h0) begin
      dir_q <= !inward;
    end
  end

  assign step_out = step_q;
  assign step_dir_out = dir_q;
  assign cylinder = cyl_q;
  assign seeking = moving || (timer_q != 32'h0);

endmodule

// file: testbench/fhd_props_properties.sv
// concurrent checks on the host and drive control ports
// assumes binding into fhd_host_drive, one clock domain, reset active low
`timescale 1ns/100ps
module fhd_props #(
  parameter int PULSE_CYCLES = 2
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // host side
  input wire fhd_pkg::fhd_bus_req_t HOST_BUS,
  input wire logic HOST_SEL_N,
  input wire logic DMA_ACK_N,
  input wire logic [7:0] HOST_RDATA,
  input wire logic DMA_REQUEST,
  input wire logic INTERRUPT,
  // core side
  input wire logic CORE_XFER_NEEDED,
  input wire logic CORE_ATTENTION,
  input wire logic [7:0] CORE_RDATA,
  input wire logic CORE_RD,
  input wire logic [1:0] EFFECTIVE_RATE,
  // drive side
  input wire logic SPINDLE_TYPE_IN,
  input wire logic DRIVE0_SELECT_N,
  input wire logic DRIVE1_SELECT_N,
  input wire logic DRIVE2_SELECT_N,
  input wire logic DRIVE3_SELECT_N,
  input wire logic MOTOR0_ENABLE_OUT,
  input wire logic STEP_OUT,
  input wire logic STEP_DIR_OUT,
  input wire logic FILTER_LOW_RATE_ON,
  input wire logic FILTER_MID_RATE_ON
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // ==========================================================
  // helper state
  logic en_q, rw_q, dma_on;
  logic [7:0] hi_cnt_q;
  assign dma_on = !DMA_ACK_N && en_q;
  // shadow of the enable and read/write bits as the host writes them
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      en_q <= 1'b0;
      rw_q <= 1'b0;
    end else if (HOST_BUS.wr && !HOST_SEL_N && !dma_on) begin
      if (HOST_BUS.addr == fhd_pkg::FHD_OFS_DRIVE_CTL) en_q <= HOST_BUS.wdata[3];
      if (HOST_BUS.addr == fhd_pkg::FHD_OFS_OP_CTL) rw_q <= |HOST_BUS.wdata[2:1];
    end
  end
  // length of the current step pulse
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) hi_cnt_q <= 8'h00;
    else hi_cnt_q <= STEP_OUT ? hi_cnt_q + 8'h01 : 8'h00;
  end
  // ==========================================================
  // assertions
  sel_motor_a: assert property (!DRIVE0_SELECT_N |-> $past(MOTOR0_ENABLE_OUT))
    else $error("drive 0 selected without its motor");
  sel_single_a: assert property ($onehot0(~{DRIVE3_SELECT_N, DRIVE2_SELECT_N,
    DRIVE1_SELECT_N, DRIVE0_SELECT_N})) else $error("more than one drive selected");
  int_gate_a: assert property (INTERRUPT == $past(CORE_ATTENTION && en_q))
    else $error("interrupt does not follow gated attention");
  quiet_off_a: assert property (!en_q && !$past(en_q) |-> !DMA_REQUEST && !INTERRUPT)
    else $error("request or interrupt active while disabled");
  dreq_rise_a: assert property ($rose(DMA_REQUEST) |-> $past(CORE_XFER_NEEDED && en_q))
    else $error("dma request rose without cause");
  dma_clear_a: assert property (dma_on && (HOST_BUS.rd || HOST_BUS.wr)
    && !CORE_XFER_NEEDED |=> !DMA_REQUEST) else $error("dma request not cleared");
  dma_read_a: assert property (dma_on && HOST_BUS.rd |=>
    CORE_RD && HOST_RDATA == $past(CORE_RDATA)) else $error("dma read data wrong");
  host_gate_a: assert property (HOST_SEL_N && !dma_on && HOST_BUS.rd |=> HOST_RDATA == 8'h00)
    else $error("read answered without select");
  rw_dir_a: assert property (rw_q && $past(rw_q) |-> STEP_DIR_OUT && !$rose(STEP_OUT))
    else $error("direction low or stepping during read or write");
  rate_sub_a: assert property (!SPINDLE_TYPE_IN && !$past(SPINDLE_TYPE_IN)
    |-> EFFECTIVE_RATE != fhd_pkg::FHD_RATE_300K) else $error("300k used with low spindle");
  filter_sel_a: assert property ($stable(EFFECTIVE_RATE) |->
    FILTER_MID_RATE_ON == (EFFECTIVE_RATE == 2'h0) &&
    FILTER_LOW_RATE_ON == (EFFECTIVE_RATE inside {2'h1, 2'h2})) else $error("filter wrong");
  step_width_a: assert property ($fell(STEP_OUT) |-> hi_cnt_q == PULSE_CYCLES)
    else $error("step pulse width wrong");
endmodule

bind fhd_host_drive fhd_props #(.PULSE_CYCLES(PULSE_CYCLES)) i_props (
  .CLOCK, .RESETN, .HOST_BUS, .HOST_SEL_N, .DMA_ACK_N, .HOST_RDATA, .DMA_REQUEST,
  .INTERRUPT, .CORE_XFER_NEEDED, .CORE_ATTENTION, .CORE_RDATA, .CORE_RD,
  .EFFECTIVE_RATE, .SPINDLE_TYPE_IN, .DRIVE0_SELECT_N, .DRIVE1_SELECT_N,
  .DRIVE2_SELECT_N, .DRIVE3_SELECT_N, .MOTOR0_ENABLE_OUT, .STEP_OUT, .STEP_DIR_OUT,
  .FILTER_LOW_RATE_ON, .FILTER_MID_RATE_ON
);

// file: testbench/fhd_drive_model.sv
// drive end model: head position follows step pulses
// assumes step and direction come straight from the block, same clock
`timescale 1ns/100ps
module fhd_drive_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // drive pins
  input wire logic step_in,
  input wire logic dir_in,
  // head position
  output logic [11:0] head
);
  logic step_q;
  // one track per rising step, low direction moves inward
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 1'b0;
      head <= 12'h000;
    end else begin
      step_q <= step_in;
      if (step_in && !step_q) head <= dir_in ? head - 12'h001 : head + 12'h001;
    end
  end
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the host and drive control block
// assumes the drive model and the bound checker are compiled alongside
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("[ERR] %0t got %h exp %h", $time, got, exp); \
    end \
  end
module tb_top;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  fhd_pkg::fhd_bus_req_t bus = '0;
  logic sel_n = 1'b1, ack_n = 1'b1, xfer = 1'b0, att = 1'b0;
  logic spindle = 1'b0, media = 1'b0;
  logic [7:0] core_rdata = 8'h00;
  logic [7:0] rdata, core_wdata, precomp;
  logic [3:0] motors;
  logic [1:0] eff;
  logic [11:0] head;
  logic dreq, irq, core_wr, core_rd, d0_n, d1_n, d2_n, d3_n, step, dir, flt_low, flt_mid, lc;
  int mismatches = 0, num_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  fhd_host_drive #(.STEP_CYCLES(20), .PULSE_CYCLES(2)) i_dut (
    .CLOCK(clk), .RESETN(rst_n), .HOST_BUS(bus), .HOST_SEL_N(sel_n), .DMA_ACK_N(ack_n),
    .HOST_RDATA(rdata), .DMA_REQUEST(dreq), .INTERRUPT(irq), .CORE_XFER_NEEDED(xfer),
    .CORE_ATTENTION(att), .CORE_RDATA(core_rdata), .CORE_WDATA(core_wdata),
    .CORE_WR(core_wr), .CORE_RD(core_rd), .PRECOMP_NS(precomp), .EFFECTIVE_RATE(eff),
    .SPINDLE_TYPE_IN(spindle), .MEDIA_CHANGED_IN(media), .DRIVE0_SELECT_N(d0_n),
    .DRIVE1_SELECT_N(d1_n), .DRIVE2_SELECT_N(d2_n), .DRIVE3_SELECT_N(d3_n),
    .MOTOR0_ENABLE_OUT(motors[0]), .MOTOR1_ENABLE_OUT(motors[1]),
    .MOTOR2_ENABLE_OUT(motors[2]), .MOTOR3_ENABLE_OUT(motors[3]),
    .SPINDLE_SPEED_LOW_CURRENT(lc), .STEP_OUT(step), .STEP_DIR_OUT(dir),
    .FILTER_LOW_RATE_ON(flt_low), .FILTER_MID_RATE_ON(flt_mid)
  );
  fhd_drive_model i_drive (.clk(clk), .rst_n(rst_n), .step_in(step), .dir_in(dir), .head(head));
  // ==========================================================
  // bus tasks
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic op(input logic w, input logic s_n, input logic k_n, input logic [2:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    bus <= '{a, d, w, !w};
    sel_n <= s_n;
    ack_n <= k_n;
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    sel_n <= 1'b1;
    ack_n <= 1'b1;
    #1;
    q = rdata;
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    op(1'b1, 1'b0, 1'b1, a, d, q);
  endtask
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] q);
    op(1'b0, 1'b0, 1'b1, a, 8'h00, q);
  endtask
  task automatic pulse_xfer();
    @(posedge clk);
    xfer <= 1'b1;
    @(posedge clk);
    xfer <= 1'b0;
    tk(1);
  endtask
  task automatic wait_head(input logic [11:0] h);
    int n;
    n = 0;
    while (head !== h && n < 9000) begin
      tk(1);
      n++;
    end
    tk(50);
    `CHK(head, h)
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    `CHK({d3_n, d2_n, d1_n, d0_n, dir}, 5'h1f)
    `CHK({dreq, irq, precomp}, 10'h07d)
  endtask
  task automatic t_select();
    for (int d = 0; d < 4; d++) begin
      reg_wr(3'h2, 8'(8'h10 << ((d + 1) % 4)) | 8'(d));
      tk(2);
      `CHK({d3_n, d2_n, d1_n, d0_n}, 4'hf)
      reg_wr(3'h2, 8'(8'h10 << d) | 8'(d));
      tk(2);
      `CHK({d3_n, d2_n, d1_n, d0_n}, ~(4'h1 << d))
      `CHK(motors, 4'h1 << d)
    end
  endtask
  task automatic t_rate();
    logic [1:0] e;
    logic [7:0] p;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      spindle <= i[3];
      reg_wr(3'h3, 8'(i[2]));
      reg_wr(3'h7, 8'(i[1:0]));
      tk(3);
      e = (i[1:0] == 2'h1 && !i[3]) ? 2'h2 : 2'(i[1:0]);
      p = (e == 2'h3) ? 8'h53 : !i[2] ? 8'h7d : (e == 2'h1) ? 8'hd0 : (e == 2'h2) ? 8'hfa : 8'h7d;
      `CHK(eff, e)
      `CHK(precomp, p)
      `CHK({flt_low, flt_mid}, {e inside {2'h1, 2'h2}, e == 2'h0})
      `CHK(lc, e inside {2'h0, 2'h3})
    end
  endtask
  task automatic t_regs();
    logic [7:0] q;
    @(posedge clk);
    media <= 1'b1;
    tk(2);
    reg_rd(3'h7, q);
    `CHK(q, 8'h00)
    @(posedge clk);
    media <= 1'b0;
    tk(2);
    reg_rd(3'h7, q);
    `CHK(q, 8'h80)
    reg_rd(3'h6, q);
    `CHK(q, 8'h00)
    op(1'b0, 1'b1, 1'b1, 3'h7, 8'h00, q);
    `CHK(q, 8'h00)
    op(1'b1, 1'b1, 1'b1, 3'h2, 8'h21, q);
    tk(2);
    `CHK({d3_n, d1_n}, 2'b01)
  endtask
  task automatic t_dma();
    logic [7:0] q;
    reg_wr(3'h2, 8'h08);
    @(posedge clk);
    att <= 1'b1;
    core_rdata <= 8'h5a;
    pulse_xfer();
    `CHK({dreq, irq}, 2'b11)
    op(1'b0, 1'b1, 1'b0, 3'h2, 8'h00, q);
    `CHK({dreq, core_rd, q}, 10'h15a)
    op(1'b1, 1'b1, 1'b0, 3'h7, 8'h3c, q);
    `CHK({core_wr, core_wdata}, 9'h13c)
    tk(2);
    `CHK(eff, 2'h3)
    pulse_xfer();
    reg_wr(3'h2, 8'h00);
    tk(2);
    `CHK({dreq, irq}, 2'b00)
    pulse_xfer();
    op(1'b0, 1'b1, 1'b0, 3'h5, 8'h00, q);
    `CHK({dreq, irq, core_rd, q}, 11'h000)
    @(posedge clk);
    att <= 1'b0;
  endtask
  task automatic t_seek();
    logic [7:0] q;
    reg_wr(3'h0, 8'h03);
    wait_head(12'h003);
    `CHK(dir, 1'b0)
    reg_rd(3'h0, q);
    `CHK(q, 8'h03)
    reg_wr(3'h1, 8'h01);
    wait_head(12'h103);
    reg_rd(3'h1, q);
    `CHK(q, 8'h01)
    reg_wr(3'h1, 8'h00);
    reg_wr(3'h0, 8'h00);
    wait_head(12'h000);
    `CHK(dir, 1'b1)
    reg_wr(3'h3, 8'h02);
    reg_wr(3'h0, 8'h05);
    tk(100);
    `CHK({head, dir}, 13'h0001)
    reg_wr(3'h3, 8'h00);
    wait_head(12'h005);
    reg_wr(3'h3, 8'h04);
    tk(2);
    `CHK(dir, 1'b1)
  endtask
  // ==========================================================
  // verdict, hang guard and main sequence
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    tk(1);
    t_reset();
    t_select();
    t_rate();
    t_regs();
    t_dma();
    t_seek();
    close_out();
  end
endmodule
